// >>> verilog/cce_evaluator.sv
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module cce_evaluator (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// message engine results
	input wire logic msg_done,
	input wire cce_pkg::cce_msg_kind_type msg_kind,
	input wire logic fmt_err,
	input wire logic no_resp,
	input wire logic loopback_err,
	input wire logic status_valid,
	input wire logic [15:0] rx_status_word,
	input wire logic [4:0] expected_rt_addr,
	input wire logic [15:0] msg_ctrl_word,
	input wire logic [1:0] retry_count,
	// instruction sequencer
	input wire logic eval_req,
	input wire logic [4:0] eval_code,
	input wire logic eval_conditional,
	input wire logic [7:0] ext_cond,
	output logic exec_go,
	output logic skip_next,
	output logic eval_true,
	// interrupt
	output logic irq
);
	// ----------------------------------------
	// per-message result flags
	// ----------------------------------------
	logic reply_absent_r, reply_absent_nxt;
	logic malformed_r, malformed_nxt;
	logic error_free_r, error_free_nxt;
	logic masked_r, masked_nxt;
	logic failed_r, failed_nxt;
	logic [1:0] retries_r, retries_nxt;
	logic mask_hit_now;
	logic addr_bad;
	logic msg_invalid;
	logic bcast_en_r, bcast_en_nxt;

	cce_status_mask u_mask (
		.ctrl_word(msg_ctrl_word),
		.status_word(rx_status_word),
		.status_valid(status_valid),
		.bcast_mask_en(bcast_en_r),
		.masked_status_hit(mask_hit_now)
	);

	always_comb begin
		addr_bad = status_valid
			&& (rx_status_word[cce_pkg::SW_ADDR_HI:cce_pkg::SW_ADDR_LO] != expected_rt_addr);
		msg_invalid = fmt_err || no_resp || loopback_err || addr_bad;
		reply_absent_nxt = reply_absent_r;
		malformed_nxt = malformed_r;
		error_free_nxt = error_free_r;
		masked_nxt = masked_r;
		failed_nxt = failed_r;
		retries_nxt = retries_r;
		// all flags move in one edge so tests never see a mix
		if (msg_done) begin
			reply_absent_nxt = no_resp;
			malformed_nxt = fmt_err || addr_bad;
			failed_nxt = fmt_err || no_resp || loopback_err;
			masked_nxt = mask_hit_now;
			retries_nxt = retry_count;
			if (msg_invalid) begin
				error_free_nxt = 1'b0;
			end else begin
				unique case (msg_kind)
					cce_pkg::CCE_RT_TO_BC, cce_pkg::CCE_RT_TO_RT,
					cce_pkg::CCE_TX_MODE_DATA: error_free_nxt = 1'b1;
					default: error_free_nxt = 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reply_absent_r <= 1'b0;
			malformed_r <= 1'b0;
			error_free_r <= 1'b0;
			masked_r <= 1'b0;
			failed_r <= 1'b0;
			retries_r <= cce_pkg::RETRY_NONE;
		end else begin
			reply_absent_r <= reply_absent_nxt;
			malformed_r <= malformed_nxt;
			error_free_r <= error_free_nxt;
			masked_r <= masked_nxt;
			failed_r <= failed_nxt;
			retries_r <= retries_nxt;
		end
	end

	// ----------------------------------------
	// condition evaluation
	// ----------------------------------------
	logic cond_now;
	logic exec_r, exec_nxt;
	logic skip_r, skip_nxt;
	logic true_r, true_nxt;
	logic [4:0] last_code_r, last_code_nxt;

	cce_cond_mux u_cond (
		.code(eval_code),
		.ext_cond(ext_cond),
		.reply_absent_flag(reply_absent_r),
		.malformed_reply_flag(malformed_r),
		.error_free_block_flag(error_free_r),
		.masked_status_hit(masked_r),
		.failed_message_test(failed_r),
		.retries(retries_r),
		.cond_true(cond_now)
	);

	always_comb begin
		exec_nxt = eval_req && (!eval_conditional || cond_now);
		skip_nxt = eval_req && eval_conditional && !cond_now;
		true_nxt = eval_req ? cond_now : true_r;
		last_code_nxt = eval_req ? eval_code : last_code_r;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			exec_r <= 1'b0;
			skip_r <= 1'b0;
			true_r <= 1'b0;
			last_code_r <= cce_pkg::LAST_CODE_RST;
		end else begin
			exec_r <= exec_nxt;
			skip_r <= skip_nxt;
			true_r <= true_nxt;
			last_code_r <= last_code_nxt;
		end
	end

	assign exec_go = exec_r;
	assign skip_next = skip_r;
	assign eval_true = true_r;

	// ----------------------------------------
	// ahb-lite register file
	// ----------------------------------------
	logic take;
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [2:0] int_stat_r, int_stat_nxt;
	logic [2:0] int_mask_r, int_mask_nxt;
	logic [2:0] int_set;
	logic stat_rd_clr;
	logic hit;

	always_comb begin
		// sub-word and out-of-page accesses are ignored, reads give zero
		hit = (haddr[31:8] == 24'h000000) && (hsize == cce_pkg::HSIZE_WORD);
		take = hsel && htrans[1] && hready && hit;
		wr_pend_nxt = take && hwrite;
		wr_addr_nxt = take ? haddr[7:0] : wr_addr_r;
		stat_rd_clr = take && !hwrite && (haddr[7:0] == cce_pkg::ADDR_INT_STAT);
		rdata_nxt = 32'h00000000;
		if (take && !hwrite) begin
			unique case (haddr[7:0])
				cce_pkg::ADDR_CTRL: rdata_nxt[cce_pkg::CTRL_BCAST_EN_BIT] = bcast_en_r;
				cce_pkg::ADDR_FLAGS: rdata_nxt[6:0] = {retries_r, failed_r, masked_r,
					error_free_r, malformed_r, reply_absent_r};
				cce_pkg::ADDR_INT_STAT: rdata_nxt[2:0] = int_stat_r;
				cce_pkg::ADDR_INT_MASK: rdata_nxt[2:0] = int_mask_r;
				cce_pkg::ADDR_LAST_EVAL: rdata_nxt[5:0] = {true_r, last_code_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end
		bcast_en_nxt = bcast_en_r;
		int_mask_nxt = int_mask_r;
		if (wr_pend_r && wr_addr_r == cce_pkg::ADDR_CTRL) begin
			bcast_en_nxt = hwdata[cce_pkg::CTRL_BCAST_EN_BIT];
		end
		if (wr_pend_r && wr_addr_r == cce_pkg::ADDR_INT_MASK) begin
			int_mask_nxt = hwdata[2:0];
		end
		int_set = 3'h0;
		int_set[cce_pkg::INT_MSG_DONE] = msg_done;
		int_set[cce_pkg::INT_FAILED] = msg_done && failed_nxt;
		int_set[cce_pkg::INT_MASKED] = msg_done && masked_nxt;
		// a new event in the clearing read survives
		int_stat_nxt = (stat_rd_clr ? 3'h0 : int_stat_r) | int_set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rdata_r <= 32'h00000000;
			bcast_en_r <= cce_pkg::CTRL_RST;
			int_mask_r <= cce_pkg::INT_MASK_RST;
			int_stat_r <= cce_pkg::INT_STAT_RST;
		end else begin
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			rdata_r <= rdata_nxt;
			bcast_en_r <= bcast_en_nxt;
			int_mask_r <= int_mask_nxt;
			int_stat_r <= int_stat_nxt;
		end
	end

	// zero wait state, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_r;
	assign irq = |(int_stat_r & int_mask_r);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	flags_hold_a: assert property (
		!msg_done |=> $stable({reply_absent_r, malformed_r, error_free_r,
			masked_r, failed_r, retries_r}))
		else $error("result flags changed without a message end");

	addr_mismatch_a: assert property (
		msg_done && status_valid
		&& rx_status_word[15:11] != expected_rt_addr |=> malformed_r && !error_free_r)
		else $error("wrong status address not flagged");

	error_free_set_a: assert property (
		msg_done && !fmt_err && !no_resp && !loopback_err && !addr_bad
		&& msg_kind == cce_pkg::CCE_RT_TO_RT |=> error_free_r)
		else $error("error-free flag not set");

	error_free_clr_a: assert property (
		msg_done && (no_resp || msg_kind == cce_pkg::CCE_BC_TO_RT) |=> !error_free_r)
		else $error("error-free flag not cleared");

	bit_mask_a: assert property (
		msg_done && status_valid && !msg_ctrl_word[12] && rx_status_word[3] |=> masked_r)
		else $error("unmasked busy bit missed");

	rsvd_mask_a: assert property (
		msg_done && status_valid && !msg_ctrl_word[9] && rx_status_word[6] |=> masked_r)
		else $error("reserved status bit missed");

	bcast_mask_a: assert property (
		msg_done && status_valid && bcast_en_r && !msg_ctrl_word[5] && rx_status_word[4]
		|=> masked_r)
		else $error("broadcast status bit missed");

	failed_test_a: assert property (
		eval_req && eval_conditional && eval_code[3:0] == 4'hC
		|=> eval_true == ($past(failed_r) ^ $past(eval_code[4])))
		else $error("failed message test wrong");

	failed_indep_a: assert property (
		msg_done && !fmt_err && !no_resp && !loopback_err |=> !failed_r)
		else $error("failed test touched by other causes");

	retry_test_a: assert property (
		eval_req && eval_code == 5'h1D |=> eval_true == ($past(retries_r) == 2'h0))
		else $error("no-retry test wrong");

	two_retry_a: assert property (
		eval_req && eval_code == 5'h0E |=> eval_true == ($past(retries_r) == 2'h2))
		else $error("two-retry test wrong");

	always_exec_a: assert property (
		eval_req && eval_code == 5'h0F
		|=> exec_go && !skip_next ##1 (!exec_go || $past(eval_req)))
		else $error("always condition did not execute");

	never_skip_a: assert property (
		eval_req && eval_conditional && eval_code == 5'h1F |=> skip_next && !exec_go)
		else $error("never condition did not skip");

	skip_false_a: assert property (
		skip_next |-> !exec_go && !eval_true && $past(eval_req) && $past(eval_conditional))
		else $error("skip without a false condition");

	reply_absent_a: assert property (
		eval_req && eval_code == 5'h08 |=> eval_true == $past(reply_absent_r))
		else $error("reply-absent test wrong");

	malformed_test_a: assert property (
		msg_done && fmt_err |=> malformed_r && failed_r)
		else $error("format error not flagged");
endmodule
`default_nettype wire

// >>> verilog/cce_pkg.sv
`default_nettype none
package cce_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_INT_STAT = 8'h08;
	localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
	localparam logic [7:0] ADDR_LAST_EVAL = 8'h10;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int CTRL_BCAST_EN_BIT = 0;
	localparam logic CTRL_RST = 1'h0;
	localparam int INT_W = 3;
	localparam int INT_MSG_DONE = 0;
	localparam int INT_FAILED = 1;
	localparam int INT_MASKED = 2;
	localparam logic [2:0] INT_MASK_RST = 3'h0;
	localparam logic [2:0] INT_STAT_RST = 3'h0;
	localparam logic [4:0] LAST_CODE_RST = 5'h0F;
	// ----------------------------------------
	// condition field
	// ----------------------------------------
	localparam int COND_INV_BIT = 4;
	localparam logic [3:0] SEL_REPLY_ABSENT = 4'h8;
	localparam logic [3:0] SEL_MALFORMED = 4'h9;
	localparam logic [3:0] SEL_ERROR_FREE = 4'hA;
	localparam logic [3:0] SEL_MASKED = 4'hB;
	localparam logic [3:0] SEL_FAILED = 4'hC;
	localparam logic [3:0] SEL_RETRY_ANY = 4'hD;
	localparam logic [3:0] SEL_RETRY_TWO = 4'hE;
	localparam logic [3:0] SEL_ALWAYS = 4'hF;
	localparam logic [1:0] RETRY_NONE = 2'h0;
	localparam logic [1:0] RETRY_TWO = 2'h2;
	// ----------------------------------------
	// control word and status word fields
	// ----------------------------------------
	localparam int CW_MASK_BCAST_BIT = 5;
	localparam int CW_RSVD_MASK_BIT = 9;
	localparam int CW_MERR_MASK_BIT = 14;
	localparam int CW_SREQ_MASK_BIT = 13;
	localparam int CW_BUSY_MASK_BIT = 12;
	localparam int CW_SUBS_MASK_BIT = 11;
	localparam int CW_TFLG_MASK_BIT = 10;
	localparam int SW_MERR_BIT = 10;
	localparam int SW_SREQ_BIT = 8;
	localparam int SW_BUSY_BIT = 3;
	localparam int SW_SUBS_BIT = 2;
	localparam int SW_TFLG_BIT = 0;
	localparam int SW_RSVD_LO = 5;
	localparam int SW_RSVD_HI = 7;
	localparam int SW_BCAST_BIT = 4;
	localparam int SW_ADDR_LO = 11;
	localparam int SW_ADDR_HI = 15;
	// ----------------------------------------
	// message kinds reported by the message engine
	// ----------------------------------------
	typedef enum logic [2:0] {
		CCE_RT_TO_BC = 3'h0,
		CCE_RT_TO_RT = 3'h1,
		CCE_TX_MODE_DATA = 3'h2,
		CCE_BC_TO_RT = 3'h3,
		CCE_RX_MODE_DATA = 3'h4,
		CCE_MODE_NO_DATA = 3'h5
	} cce_msg_kind_type;
endpackage
`default_nettype wire

// >>> verilog/cce_status_mask.sv
`timescale 1ns/1ps
`default_nettype none
module cce_status_mask (
	// message words
	input wire logic [15:0] ctrl_word,
	input wire logic [15:0] status_word,
	input wire logic status_valid,
	// configuration
	input wire logic bcast_mask_en,
	// result
	output logic masked_status_hit
);
	logic bit_hit;
	logic rsvd_hit;
	logic bcast_hit;

	always_comb begin
		// mask bit low means the status bit is watched
		bit_hit = (!ctrl_word[cce_pkg::CW_MERR_MASK_BIT] && status_word[cce_pkg::SW_MERR_BIT])
			|| (!ctrl_word[cce_pkg::CW_SREQ_MASK_BIT] && status_word[cce_pkg::SW_SREQ_BIT])
			|| (!ctrl_word[cce_pkg::CW_BUSY_MASK_BIT] && status_word[cce_pkg::SW_BUSY_BIT])
			|| (!ctrl_word[cce_pkg::CW_SUBS_MASK_BIT] && status_word[cce_pkg::SW_SUBS_BIT])
			|| (!ctrl_word[cce_pkg::CW_TFLG_MASK_BIT] && status_word[cce_pkg::SW_TFLG_BIT]);
		rsvd_hit = !ctrl_word[cce_pkg::CW_RSVD_MASK_BIT]
			&& (|status_word[cce_pkg::SW_RSVD_HI:cce_pkg::SW_RSVD_LO]);
		bcast_hit = bcast_mask_en && !ctrl_word[cce_pkg::CW_MASK_BCAST_BIT]
			&& status_word[cce_pkg::SW_BCAST_BIT];
		// no status word received: nothing to compare
		masked_status_hit = status_valid && (bit_hit || rsvd_hit || bcast_hit);
	end
endmodule
`default_nettype wire

// >>> verilog/cce_cond_mux.sv
`timescale 1ns/1ps
`default_nettype none
module cce_cond_mux (
	// condition field
	input wire logic [4:0] code,
	// tests kept outside this block
	input wire logic [7:0] ext_cond,
	// per-message flags
	input wire logic reply_absent_flag,
	input wire logic malformed_reply_flag,
	input wire logic error_free_block_flag,
	input wire logic masked_status_hit,
	input wire logic failed_message_test,
	input wire logic [1:0] retries,
	// result
	output logic cond_true
);
	logic plain;
	logic inv;
	logic single_retry_test;
	logic double_retry_test;

	always_comb begin
		inv = code[cce_pkg::COND_INV_BIT];
		single_retry_test = (retries != cce_pkg::RETRY_NONE);
		double_retry_test = (retries == cce_pkg::RETRY_TWO);
		plain = 1'b0;
		if (!code[3]) begin
			plain = ext_cond[code[2:0]];
		end else begin
			unique case (code[3:0])
				cce_pkg::SEL_REPLY_ABSENT: plain = reply_absent_flag;
				cce_pkg::SEL_MALFORMED: plain = malformed_reply_flag;
				cce_pkg::SEL_ERROR_FREE: plain = error_free_block_flag;
				cce_pkg::SEL_MASKED: plain = masked_status_hit;
				cce_pkg::SEL_FAILED: plain = failed_message_test;
				cce_pkg::SEL_RETRY_ANY: plain = single_retry_test;
				cce_pkg::SEL_RETRY_TWO: plain = double_retry_test;
				cce_pkg::SEL_ALWAYS: plain = 1'b1;
				default: plain = 1'b0;
			endcase
		end
		// undefined inverse of two-retry test reads false
		if (inv && code[3:0] == cce_pkg::SEL_RETRY_TWO) begin
			cond_true = 1'b0;
		end else begin
			cond_true = plain ^ inv;
		end
	end
endmodule
`default_nettype wire

// >>> verification/cce_msg_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module cce_msg_engine_model (
	// clock
	input wire logic hclk,
	// message results
	output logic msg_done,
	output cce_pkg::cce_msg_kind_type msg_kind,
	output logic fmt_err,
	output logic no_resp,
	output logic loopback_err,
	output logic status_valid,
	output logic [15:0] rx_status_word,
	output logic [4:0] expected_rt_addr,
	output logic [15:0] msg_ctrl_word,
	output logic [1:0] retry_count
);
	initial begin
		msg_done = 1'h0;
		msg_kind = cce_pkg::CCE_RT_TO_BC;
		{fmt_err, no_resp, loopback_err, status_valid} = 4'h0;
		rx_status_word = 16'h0000;
		expected_rt_addr = 5'h05;
		msg_ctrl_word = 16'h0000;
		retry_count = 2'h0;
	end
	// one completed message; err is {format, no reply, loopback}
	task automatic send(input cce_pkg::cce_msg_kind_type k, input logic [2:0] err,
			input logic [15:0] sw, input logic [15:0] cw, input logic [1:0] rc);
		@(posedge hclk);
		msg_done <= 1'h1;
		msg_kind <= k;
		{fmt_err, no_resp, loopback_err} <= err;
		status_valid <= ~err[1];
		rx_status_word <= sw;
		msg_ctrl_word <= cw;
		retry_count <= rc;
		@(posedge hclk);
		// results only hold with the pulse: scramble them so stale use shows
		msg_done <= 1'h0;
		msg_kind <= cce_pkg::cce_msg_kind_type'(~k);
		{fmt_err, no_resp, loopback_err} <= ~err;
		rx_status_word <= ~sw;
		msg_ctrl_word <= ~cw;
		retry_count <= ~rc;
	endtask
endmodule
`default_nettype wire

// >>> verification/bc_condition_code_evaluator_test.sv
`timescale 1ns/1ps
`default_nettype none
module bc_condition_code_evaluator_test;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, msg_done, fmt_err, no_resp;
	logic loopback_err, status_valid, eval_req, eval_conditional, exec_go, skip_next;
	logic eval_true, irq;
	logic [31:0] haddr, hwdata, hrdata, rd_q;
	logic [1:0] htrans, retry_count;
	logic [2:0] hsize;
	logic [15:0] rx_status_word, msg_ctrl_word;
	logic [4:0] expected_rt_addr, eval_code;
	logic [7:0] ext_cond;
	cce_pkg::cce_msg_kind_type msg_kind;
	int mismatches = 0;
	int checks = 0;
	initial hclk = 1'h0;
	always #25 hclk = ~hclk;
	always @(posedge hclk) rd_q <= hrdata;
	cce_evaluator u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .msg_done(msg_done),
		.msg_kind(msg_kind), .fmt_err(fmt_err), .no_resp(no_resp),
		.loopback_err(loopback_err), .status_valid(status_valid),
		.rx_status_word(rx_status_word), .expected_rt_addr(expected_rt_addr),
		.msg_ctrl_word(msg_ctrl_word), .retry_count(retry_count), .eval_req(eval_req),
		.eval_code(eval_code), .eval_conditional(eval_conditional), .ext_cond(ext_cond),
		.exec_go(exec_go), .skip_next(skip_next), .eval_true(eval_true), .irq(irq));
	cce_msg_engine_model u_eng (.hclk(hclk), .msg_done(msg_done), .msg_kind(msg_kind),
		.fmt_err(fmt_err), .no_resp(no_resp), .loopback_err(loopback_err),
		.status_valid(status_valid), .rx_status_word(rx_status_word),
		.expected_rt_addr(expected_rt_addr), .msg_ctrl_word(msg_ctrl_word),
		.retry_count(retry_count));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		if (mismatches == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= cce_pkg::HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= wd;
		// rd_q holds hrdata as it stood just before the edge, free of races
		do @(posedge hclk); while (hreadyout !== 1'h1);
		#1 rd = rd_q;
	endtask
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] v;
		ahb(1'h0, a, 32'h0, v);
		check(v, exp);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] v;
		ahb(1'h1, a, d, v);
	endtask
	// ev: conditional flag, code, expected result of the test
	task automatic ev(input logic c, input logic [4:0] code, input logic exp);
		@(posedge hclk);
		eval_req <= 1'h1;
		eval_code <= code;
		eval_conditional <= c;
		@(posedge hclk);
		eval_req <= 1'h0;
		#10 check({exec_go, skip_next, eval_true}, {~c | exp, c & ~exp, exp});
	endtask
	task automatic msg(input logic [2:0] k, input logic [2:0] e, input logic [15:0] sw,
			input logic [15:0] cw, input logic [1:0] rc);
		u_eng.send(cce_pkg::cce_msg_kind_type'(k), e, sw, cw, rc);
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		check({exec_go, skip_next, eval_true, irq}, 32'h0);
		check({hreadyout, hresp}, 32'h2);
		rd_chk(32'h00, 32'h0);
		rd_chk(32'h0C, 32'h0);
		rd_chk(32'h10, 32'h0F);
		rd_chk(32'h14, 32'h0);
		wr(32'h14, 32'hFFFFFFFF);
		rd_chk(32'h14, 32'h0);
	endtask
	task automatic t_select;
		for (int s = 0; s < 8; s++) ev(1'h1, 5'(s), ext_cond[s]);
		for (int s = 0; s < 8; s++) ev(1'h1, 5'(s) | 5'h10, ~ext_cond[s]);
		ev(1'h1, 5'h0F, 1'h1);
		ev(1'h1, 5'h1F, 1'h0);
		rd_chk(32'h10, 32'h1F);
		ev(1'h0, 5'h1F, 1'h0);
	endtask
	task automatic t_block;
		for (int k = 0; k < 6; k++) begin
			msg(3'(k), 3'h0, 16'h2800, 16'h7E20, 2'h0);
			ev(1'h1, 5'h0A, k < 3);
			ev(1'h1, 5'h0A, k < 3);
		end
		msg(3'h0, 3'h4, 16'h2800, 16'h7E20, 2'h0);
		ev(1'h1, 5'h0A, 1'h0);
		ev(1'h1, 5'h09, 1'h1);
		ev(1'h1, 5'h0C, 1'h1);
		ev(1'h1, 5'h1C, 1'h0);
		msg(3'h0, 3'h2, 16'h0000, 16'h7E20, 2'h0);
		ev(1'h1, 5'h08, 1'h1);
		ev(1'h1, 5'h0C, 1'h1);
		msg(3'h0, 3'h1, 16'h2800, 16'h7E20, 2'h0);
		ev(1'h1, 5'h0C, 1'h1);
		ev(1'h1, 5'h08, 1'h0);
		msg(3'h0, 3'h0, 16'h3000, 16'h7E20, 2'h0);
		ev(1'h1, 5'h09, 1'h1);
		ev(1'h1, 5'h0A, 1'h0);
	endtask
	task automatic t_masked;
		msg(3'h0, 3'h0, 16'h2C00, 16'h3E20, 2'h0);
		ev(1'h1, 5'h0B, 1'h1);
		ev(1'h1, 5'h0C, 1'h0);
		ev(1'h1, 5'h1C, 1'h1);
		msg(3'h0, 3'h0, 16'h2C00, 16'h7E20, 2'h0);
		ev(1'h1, 5'h0B, 1'h0);
		msg(3'h0, 3'h0, 16'h2808, 16'h6E20, 2'h0);
		ev(1'h1, 5'h0B, 1'h1);
		msg(3'h0, 3'h0, 16'h2840, 16'h7C20, 2'h0);
		ev(1'h1, 5'h0B, 1'h1);
		msg(3'h0, 3'h0, 16'h2810, 16'h7E00, 2'h0);
		ev(1'h1, 5'h0B, 1'h0);
		wr(32'h00, 32'h1);
		rd_chk(32'h00, 32'h1);
		msg(3'h0, 3'h0, 16'h2810, 16'h7E00, 2'h0);
		ev(1'h1, 5'h0B, 1'h1);
		msg(3'h0, 3'h0, 16'h2810, 16'h7E20, 2'h0);
		ev(1'h1, 5'h0B, 1'h0);
	endtask
	task automatic t_retry;
		for (int r = 0; r < 3; r++) begin
			msg(3'h0, 3'h0, 16'h2800, 16'h7E20, 2'(r));
			ev(1'h1, 5'h0D, r != 0);
			ev(1'h1, 5'h1D, r == 0);
			ev(1'h1, 5'h0E, r == 2);
		end
		rd_chk(32'h04, 32'h44);
	endtask
	task automatic t_irq;
		logic [31:0] v;
		wr(32'h0C, 32'h1);
		ahb(1'h0, 32'h08, 32'h0, v);
		#10 check(irq, 1'h0);
		msg(3'h0, 3'h0, 16'h2800, 16'h7E20, 2'h0);
		#10 check(irq, 1'h1);
		rd_chk(32'h08, 32'h1);
		#10 check(irq, 1'h0);
		wr(32'h0C, 32'h0);
		msg(3'h0, 3'h4, 16'h2800, 16'h7E20, 2'h0);
		#10 check(irq, 1'h0);
		rd_chk(32'h08, 32'h3);
	endtask
	initial begin
		{hresetn, hsel, hwrite, eval_req, eval_conditional} = 5'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		eval_code = 5'h0;
		ext_cond = 8'hA5;
		repeat (20) @(posedge hclk);
		hresetn <= 1'h1;
		t_regs;
		t_select;
		t_block;
		t_masked;
		t_retry;
		t_irq;
		print_verdict;
	end
	initial begin
		#(5000 * 50);
		mismatches++;
		print_verdict;
	end
endmodule
`default_nettype wire
